// ### include/dsp_alu_consts.svh
// constant definitions for the data-unit opcode decoder
`ifndef DSP_ALU_CONSTS_SVH
`define DSP_ALU_CONSTS_SVH
`define ARITH_SEL_BIT   6'd59
`define OP_HI_BIT       6'd58
`define OP_LO_BIT       6'd51
`define MISC_HI_BIT     6'd43
`define MISC_LO_BIT     6'd39
`define CLASS_HI_BIT    6'd50
`define CLASS_LO_BIT    6'd48
`define DATA_W          32
`define PART_W          8
`define PARTS           4
`define MISC_NOP        5'h00
`define MISC_QWAIT      5'h01
`define MISC_EINT       5'h02
`define MISC_DINT       5'h03
`define MISC_ELOOP      5'h04
`define MISC_DLOOP      5'h05
`define MISC_FIRST_RSV  5'h06
`define MOD_FLAG_CARRY  4'h8
`define MOD_FLAG_STATUS 4'h9
`define MOD_ROT_CARRY   4'hA
`define MOD_ROT_STATUS  4'hB
`define MOD_CLR_CARRY   4'hC
`define MOD_CLR_STATUS  4'hD
`define MOD_NO_UPDATE   4'hE
`define MOD_RESERVED    4'hF
`define AR_SUB_BORNC    4'h4
`define AR_ADD_BORNC    4'hB
`define AR_PP_ADD       4'h6
`define AR_PP_SUB       4'h9
`endif

// ### include/dsp_alu_pkg.sv
// types shared by the data-unit opcode decoder
package dsp_alu_pkg;
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
  } alu_ops_t;
  typedef struct packed {
    logic [31:0] result;
    logic [3:0]  part_carry;
  } alu_res_t;
  typedef enum logic [3:0] {
    MF_KEEP        = 4'h0,
    MF_CARRY       = 4'h1,
    MF_STATUS      = 4'h2,
    MF_ROT_CARRY   = 4'h3,
    MF_ROT_STATUS  = 4'h4,
    MF_CLR_CARRY   = 4'h5,
    MF_CLR_STATUS  = 4'h6
  } mf_mode_t;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_QWAIT = 2'b01
  } du_state_t;
endpackage : dsp_alu_pkg

// ### core/bool_unit.sv
// three-input minterm boolean function
`timescale 1ns/1ps
module bool_unit
  import dsp_alu_pkg::*;
(
  input  wire logic [7:0]  fsel,   // minterm enables, bit 7 = a&b&c
  input  wire alu_ops_t    ops,    // operands
  output logic      [31:0] y       // result
);
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      assign y[i] = fsel[{ops.c[i], ops.b[i], ops.a[i]}];
    end
  endgenerate
endmodule : bool_unit

// ### core/arith_unit.sv
// per-part adder with carry-in per byte part
`timescale 1ns/1ps
module arith_unit
  import dsp_alu_pkg::*;
(
  input  wire logic [31:0] a,      // a operand
  input  wire logic [31:0] b,      // b operand, already inverted for subtract
  input  wire logic [3:0]  cin,    // carry-in per part
  input  wire logic [3:0]  chain,  // 1 feeds previous part carry into this part
  output alu_res_t         res     // sum and part carry outs
);
  logic [4:0] carry;
  assign carry[0] = cin[0];
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_part
      logic [8:0] s;
      logic       ci;
      assign ci = chain[p] ? carry[p] : cin[p];
      assign s = {1'b0, a[p*8 +: 8]} + {1'b0, b[p*8 +: 8]} + {8'h00, ci};
      assign res.result[p*8 +: 8] = s[7:0];
      assign res.part_carry[p] = s[8];
      assign carry[p+1] = s[8];
    end
  endgenerate
endmodule : arith_unit

// ### core/du_opcode_decode.sv
// data-unit alu operation and misc opcode decode with flag and state updates
// Operation
// RULE1 - boolean opcodes OR the eight minterms selected by bits 58..51
// RULE2 - arithmetic opcodes take bits 57,55,53,51 as operation code
// RULE3 - arithmetic opcodes take bits 58,56,54,52 as function modifier
// RULE4 - code 0100 does A-(B|~C) carry one, or A-(B&C) when sign clear
// RULE5 - code 1011 does A+(B|~C) carry zero, or A+(B&C) when sign clear
// RULE6 - code 0110 adds or subtracts per part by mask in class 0/5, else sign
// RULE7 - code 1001 subtracts or adds per part by mask in class 0/5, else sign
// RULE8 - per-part codes take carry-in from part lsb of C, inverted for 1001
// RULE9 - masked codes realise shifted A plus or minus B via C mask
// RULE10 - modifier 56 zeroes A port, modifier 52 adds status carry
// RULE11 - modifier 54 selects mask generator or leftmost/rightmost detection
// RULE12 - modifier 1000 sets flags from carries, 1001 from status select
// RULE13 - modifiers 1010/1011 rotate flags by part size then set; code shifts left by the part count with zero fill
// RULE14 - modifiers 1100/1101 clear flags then set
// RULE15 - modifier 1110 leaves flags alone, 1111 reserved
// RULE16 - misc codes toggle global interrupt and loop enables
// RULE17 - misc nop changes nothing
// RULE18 - misc qwait stalls until queue bit clears
// RULE19 - class code selects one of eight operand routings
// RULE20 - reserved codes do nothing and update no status
`timescale 1ns/1ps
`include "dsp_alu_consts.svh"
module du_opcode_decode
  import dsp_alu_pkg::*;
(
  input  wire logic        core_clk,            // 125 MHz clock
  input  wire logic        rst_n,               // sync reset, active low
  input  wire logic        issue,               // opcode valid this cycle
  input  wire logic        misc_fmt,            // opcode is miscellaneous format
  input  wire logic [63:0] opcode,              // instruction word
  input  wire alu_ops_t    ops,                 // routed a, b, c operands
  input  wire logic [2:0]  op_class,            // operand class of opcode
  input  wire logic        sign,                // sign modifier of opcode
  input  wire logic        maskgen,             // instruction is mask generate
  input  wire logic [3:0]  mf_expand,           // mask flags expansion, one per part
  input  wire logic        status_carry,        // carry flag of status word
  input  wire logic [3:0]  mask_status_select,  // per-part flags picked by status word
  input  wire logic [1:0]  part_size,           // 0 byte, 1 half, 2 word
  input  wire logic        queue_bit,           // queue bit of comm register
  output logic [31:0]      result,              // registered alu result
  output logic             result_valid,        // result written this cycle
  output logic [3:0]       mask_flags_register, // mask flags
  output logic             gie,                 // global interrupt enable
  output logic             gloop,               // global loop enable
  output logic             stall,               // data unit stalled
  output logic             illegal_op,          // reserved code seen, pulse
  output logic [1:0]       detect_mode,         // 0 leftmost_one 1 rmo 2 leftmost_change 3 rmbc
  output logic             detect_en,           // bit detection requested
  output logic             modified_maskgen     // modified mask generator used
);
  du_state_t  state, next_state;
  logic [31:0] next_result;
  logic        next_result_valid, next_gie, next_gloop, next_illegal;
  logic [3:0]  next_mf;
  logic [1:0]  next_detect_mode;
  logic        next_detect_en, next_mmg;

  logic        arith;
  logic [7:0]  bool_sel;
  logic [3:0]  ar_code, mod_code;
  logic [4:0]  misc_code;
  assign arith     = opcode[`ARITH_SEL_BIT];
  assign bool_sel  = opcode[`OP_HI_BIT:`OP_LO_BIT];                  // RULE1
  assign ar_code   = {opcode[57], opcode[55], opcode[53], opcode[51]}; // RULE2
  assign mod_code  = {opcode[58], opcode[56], opcode[54], opcode[52]}; // RULE3
  assign misc_code = opcode[`MISC_HI_BIT:`MISC_LO_BIT];

  alu_ops_t   bops;
  logic [31:0] bool_y;
  bool_unit u_bool (
    .fsel (bool_sel),
    .ops  (bops),
    .y    (bool_y)
  );

  // arithmetic operand shaping
  logic        a_zero, masked_class;
  logic [31:0] a_in, a_add, b_eff, b_add;
  logic [3:0]  cin_v, chain_v, sub_part;
  logic        cin0, sub_all;
  alu_res_t    ares;
  assign a_zero       = arith & ~mod_code[3] & mod_code[2];             // RULE10
  assign masked_class = (op_class == 3'd0) || (op_class == 3'd5);      // RULE19
  assign a_in         = a_zero ? 32'h00000000 : ops.a;
  assign bops         = '{a: a_in, b: ops.b, c: ops.c};
  // field add masks the A port with C as well
  assign a_add        = (arith && ar_code == 4'hF) ? (a_in & ops.c) : a_in;

  always_comb begin
    b_eff    = ops.b;
    sub_all  = 1'b0;
    cin0     = 1'b0;
    sub_part = 4'h0;
    chain_v  = 4'hF;
    case (ar_code)
      4'h1: begin b_eff = ops.b | ops.c; sub_all = 1'b1; cin0 = 1'b1; end   // RULE9
      4'h2: begin b_eff = ops.b & ~ops.c; end                                 // RULE9
      4'h3: begin b_eff = ops.c; sub_all = 1'b1; cin0 = 1'b1; end
      `AR_SUB_BORNC: begin                                                    // RULE4
        b_eff = sign ? (ops.b | ~ops.c) : (ops.b & ops.c);
        sub_all = 1'b1;
        cin0 = 1'b1;
      end
      4'h5: begin sub_all = 1'b1; cin0 = 1'b1; end
      `AR_PP_ADD: begin
        if (masked_class) begin                                               // RULE6
          sub_part = ~mf_expand;
          chain_v  = 4'h0;
        end else begin
          sub_all = sign;
          cin0    = sign;
        end
      end
      4'h7: begin b_eff = ops.b & ops.c; sub_all = 1'b1; cin0 = 1'b1; end   // RULE9
      4'h8: begin b_eff = ops.b & ops.c; end                                  // RULE9
      `AR_PP_SUB: begin
        if (masked_class) begin                                               // RULE7
          sub_part = mf_expand;
          chain_v  = 4'h0;
        end else begin
          sub_all = ~sign;
          cin0    = ~sign;
        end
      end
      `AR_ADD_BORNC: b_eff = sign ? (ops.b | ~ops.c) : (ops.b & ops.c);      // RULE5
      4'hC: b_eff = ops.c;
      4'hD: begin b_eff = ops.b & ~ops.c; sub_all = 1'b1; cin0 = 1'b1; end  // RULE9
      4'hE: b_eff = ops.b | ops.c;                                            // RULE9
      4'hF: b_eff = ops.b & ops.c;
      default: b_eff = ops.b;
    endcase
  end

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_part
      logic inv;
      assign inv = sub_all | sub_part[p];
      assign b_add[p*8 +: 8] = inv ? ~b_eff[p*8 +: 8] : b_eff[p*8 +: 8];
      // per-part carry from lsb of each C part, inverted for the subtract form
      assign cin_v[p] = (chain_v[p] == 1'b0)
                        ? (ar_code == `AR_PP_SUB ? ~ops.c[p*8] : ops.c[p*8])       // RULE8
                        : ((p == 0) ? (cin0 | (status_carry & ~mod_code[3] & mod_code[0])) : 1'b0); // RULE10
    end
  endgenerate

  arith_unit u_arith (
    .a     (a_add),
    .b     (b_add),
    .cin   (cin_v),
    .chain (chain_v),
    .res   (ares)
  );

  // mask flag update mode
  mf_mode_t mf_mode;
  always_comb begin
    case (mod_code)
      `MOD_FLAG_CARRY:  mf_mode = MF_CARRY;       // RULE12
      `MOD_FLAG_STATUS: mf_mode = MF_STATUS;      // RULE12
      `MOD_ROT_CARRY:   mf_mode = MF_ROT_CARRY;   // RULE13
      `MOD_ROT_STATUS:  mf_mode = MF_ROT_STATUS;  // RULE13
      `MOD_CLR_CARRY:   mf_mode = MF_CLR_CARRY;   // RULE14
      `MOD_CLR_STATUS:  mf_mode = MF_CLR_STATUS;  // RULE14
      default:          mf_mode = MF_KEEP;        // RULE15
    endcase
  end

  logic [3:0] rot_mf, new_bits, carry_bits, status_bits;
  logic [2:0] nparts;
  always_comb begin
    case (part_size)
      2'd0:    nparts = 3'd4;
      2'd1:    nparts = 3'd2;
      default: nparts = 3'd1;
    endcase
    case (part_size)
      2'd0:    rot_mf = 4'h0;
      2'd1:    rot_mf = {mask_flags_register[1:0], 2'b00};
      default: rot_mf = {mask_flags_register[2:0], 1'b0};
    endcase
    case (part_size)
      2'd0:    carry_bits = ares.part_carry;
      2'd1:    carry_bits = {2'b00, ares.part_carry[3], ares.part_carry[1]};
      default: carry_bits = {3'b000, ares.part_carry[3]};
    endcase
    case (part_size)
      2'd0:    status_bits = mask_status_select;
      2'd1:    status_bits = {2'b00, mask_status_select[1:0]};
      default: status_bits = {3'b000, mask_status_select[0]};
    endcase
    new_bits = (mf_mode == MF_CARRY || mf_mode == MF_ROT_CARRY || mf_mode == MF_CLR_CARRY)
               ? carry_bits : status_bits;
  end

  logic legal;
  always_comb begin
    next_state        = state;
    next_result       = result;
    next_result_valid = 1'b0;
    next_mf           = mask_flags_register;
    next_gie          = gie;
    next_gloop        = gloop;
    next_illegal      = 1'b0;
    next_detect_mode  = detect_mode;
    next_detect_en    = 1'b0;
    next_mmg          = 1'b0;
    legal             = 1'b1;
    case (state)
      ST_QWAIT: begin
        if (!queue_bit) next_state = ST_RUN;  // RULE18
      end
      ST_RUN: begin
        if (issue && misc_fmt) begin
          case (misc_code)
            `MISC_NOP:   legal = 1'b1;                 // RULE17
            `MISC_QWAIT: if (queue_bit) next_state = ST_QWAIT; // RULE18
            `MISC_EINT:  next_gie = 1'b1;              // RULE16
            `MISC_DINT:  next_gie = 1'b0;              // RULE16
            `MISC_ELOOP: next_gloop = 1'b1;            // RULE16
            `MISC_DLOOP: next_gloop = 1'b0;            // RULE16
            default:     legal = 1'b0;                 // RULE20
          endcase
          next_illegal = ~legal;
        end else if (issue) begin
          if (arith && mod_code == `MOD_RESERVED) begin
            next_illegal = 1'b1;                       // RULE20
          end else begin
            next_result_valid = 1'b1;
            next_result       = arith ? ares.result : bool_y;
            if (arith) begin
              if (!mod_code[3] && mod_code[1]) begin   // RULE11
                next_mmg         = maskgen;
                next_detect_en   = ~maskgen;
                next_detect_mode = {mod_code[2], mod_code[0]};
              end
              case (mf_mode)
                MF_CARRY, MF_STATUS:         next_mf = new_bits;                // RULE12
                MF_ROT_CARRY, MF_ROT_STATUS: next_mf = rot_mf | new_bits;       // RULE13
                MF_CLR_CARRY, MF_CLR_STATUS: next_mf = new_bits & ({4{1'b1}} >> (3'd4 - nparts)); // RULE14
                default:                     next_mf = mask_flags_register;     // RULE15
              endcase
            end
          end
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state               <= ST_RUN;
      result              <= 32'h00000000;
      result_valid        <= 1'b0;
      mask_flags_register <= 4'h0;
      gie                 <= 1'b0;
      gloop               <= 1'b0;
      illegal_op          <= 1'b0;
      detect_mode         <= 2'h0;
      detect_en           <= 1'b0;
      modified_maskgen    <= 1'b0;
    end else begin
      state               <= next_state;
      result              <= next_result;
      result_valid        <= next_result_valid;
      mask_flags_register <= next_mf;
      gie                 <= next_gie;
      gloop               <= next_gloop;
      illegal_op          <= next_illegal;
      detect_mode         <= next_detect_mode;
      detect_en           <= next_detect_en;
      modified_maskgen    <= next_mmg;
    end
  end

  assign stall = (state == ST_QWAIT);  // RULE18

  bool_res_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    issue && !misc_fmt && !arith && state == ST_RUN |=> result_valid && result == $past(bool_y)) // RULE1
    else $error("boolean result not registered");
  eint_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    issue && misc_fmt && misc_code == `MISC_EINT && state == ST_RUN |=> gie) // RULE16
    else $error("interrupt enable not set");
  dint_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    issue && misc_fmt && misc_code == `MISC_DINT && state == ST_RUN |=> !gie) // RULE16
    else $error("interrupt enable not cleared");
  nop_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    issue && misc_fmt && misc_code == `MISC_NOP |=> $stable(mask_flags_register) && $stable(gie) && !result_valid) // RULE17
    else $error("nop changed state");
  qwait_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    stall && queue_bit |=> stall) // RULE18
    else $error("stall released while queue busy");
  qwait_rel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    stall && !queue_bit |=> !stall) // RULE18
    else $error("stall not released");
  no_update_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    issue && !misc_fmt && arith && mod_code == `MOD_NO_UPDATE |=> $stable(mask_flags_register)) // RULE15
    else $error("flags changed on no update");
  rsv_mod_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    issue && !misc_fmt && arith && mod_code == `MOD_RESERVED && state == ST_RUN
      |=> illegal_op && !result_valid && $stable(mask_flags_register)) // RULE20
    else $error("reserved modifier acted");
  rsv_misc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    issue && misc_fmt && misc_code >= `MISC_FIRST_RSV && state == ST_RUN
      |=> illegal_op && !result_valid && $stable(gie) && $stable(gloop)) // RULE20
    else $error("reserved misc not flagged");
endmodule : du_opcode_decode

// ### tb/issue_model.sv
// issue-side model: presents one opcode and holds it until the decoder takes it
`timescale 1ns/1ps
module issue_model (
  input  wire logic        core_clk,  // clock
  input  wire logic        rst_n,     // sync reset, active low
  input  wire logic        req,       // bench asks for one issue
  input  wire logic        req_misc,  // requested word is misc format
  input  wire logic [63:0] req_word,  // requested instruction word
  input  wire logic        stall,     // decoder stalled
  output logic             issue,     // opcode valid
  output logic             misc_fmt,  // misc format flag
  output logic [63:0]      opcode     // instruction word
);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      issue    <= 1'h0;
      misc_fmt <= 1'h0;
      opcode   <= 64'h0;
    end else if (req) begin
      issue    <= 1'h1;
      misc_fmt <= req_misc;
      opcode   <= req_word;
    end else if (issue && !stall) begin
      // word taken: show the inverse so a stale copy is never mistaken for a new one
      issue    <= 1'h0;
      misc_fmt <= ~misc_fmt;
      opcode   <= ~opcode;
    end
  end
endmodule : issue_model

// ### tb/du_opcode_decode_test.sv
// self-checking bench for the data-unit opcode decoder
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin fail_count++; $display("[ERR] %s expected %0h seen %0h", nm, ex, gt); end end
module du_opcode_decode_test
  import dsp_alu_pkg::*;
;
  typedef struct packed {
    alu_ops_t   ops;
    logic [2:0] op_class;
    logic       sign;
    logic       maskgen;
    logic       status_carry;
    logic       queue_bit;
    logic [3:0] mf_expand;
    logic [3:0] mask_status_select;
    logic [1:0] part_size;
  } drive_t;
  localparam logic [31:0] VA = 32'h12345678;
  localparam logic [31:0] VB = 32'h0F0F0F0F;
  localparam logic [31:0] VC = 32'h00FF00FF;
  logic        core_clk, rst_n, req, req_misc, issue, misc_fmt, stall, result_valid;
  logic        gie, gloop, illegal_op, detect_en, modified_maskgen;
  logic [63:0] req_word, opcode;
  logic [31:0] result;
  logic [3:0]  mask_flags_register, md;
  logic [1:0]  detect_mode;
  logic [7:0]  fs;
  drive_t      ctl, nxt;
  int          fail_count, checked;
  logic [3:0]  fm[4]   = '{4'hA, 4'hB, 4'hC, 4'hD};
  logic [3:0]  fexp[4] = '{4'hD, 4'hA, 4'h1, 4'h0};
  logic [4:0]  mc[9]   = '{5'h02, 5'h00, 5'h04, 5'h06, 5'h03, 5'h08, 5'h05, 5'h10, 5'h1F};
  logic [2:0]  mexp[9] = '{3'h2, 3'h2, 3'h3, 3'h7, 3'h1, 3'h5, 3'h0, 3'h4, 3'h4};

  issue_model issue_model_inst (.core_clk, .rst_n, .req, .req_misc, .req_word, .stall, .issue, .misc_fmt, .opcode);
  du_opcode_decode du_opcode_decode_inst (
    .core_clk, .rst_n, .issue, .misc_fmt, .opcode, .ops(ctl.ops), .op_class(ctl.op_class), .sign(ctl.sign),
    .maskgen(ctl.maskgen), .mf_expand(ctl.mf_expand), .status_carry(ctl.status_carry),
    .mask_status_select(ctl.mask_status_select), .part_size(ctl.part_size), .queue_bit(ctl.queue_bit),
    .result, .result_valid, .mask_flags_register, .gie, .gloop, .stall, .illegal_op, .detect_mode,
    .detect_en, .modified_maskgen);

  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end

  function automatic logic [63:0] arith_word(input logic [3:0] code, input logic [3:0] m);
    arith_word = 64'h0;
    arith_word[59] = 1'h1;
    {arith_word[58], arith_word[57], arith_word[56], arith_word[55], arith_word[54], arith_word[53],
     arith_word[52], arith_word[51]} = {m[3], code[3], m[2], code[2], m[1], code[1], m[0], code[0]};
  endfunction : arith_word

  function automatic logic [31:0] arith_exp(input logic [3:0] code, input logic sg, input logic [31:0] a, b, c);
    case (code)
      4'h1: arith_exp = a - (b | c);
      4'h2: arith_exp = a + (b & ~c);
      4'h3: arith_exp = a - c;
      4'h4: arith_exp = sg ? a - (b | ~c) : a - (b & c);
      4'h5: arith_exp = a - b;
      4'h6: arith_exp = sg ? a - b : a + b;
      4'h7: arith_exp = a - (b & c);
      4'h8: arith_exp = a + (b & c);
      4'h9: arith_exp = sg ? a + b : a - b;
      4'hB: arith_exp = sg ? a + (b | ~c) : a + (b & c);
      4'hC: arith_exp = a + c;
      4'hD: arith_exp = a - (b & ~c);
      4'hE: arith_exp = a + (b | c);
      4'hF: arith_exp = (a & c) + (b & c);
      default: arith_exp = a + b;
    endcase
  endfunction : arith_exp

  function automatic logic [31:0] bool_exp(input logic [7:0] f, input logic [31:0] a, b, c);
    bool_exp = ({32{f[7]}} & a & b & c) | ({32{f[6]}} & ~a & b & c) | ({32{f[5]}} & a & ~b & c)
             | ({32{f[4]}} & ~a & ~b & c) | ({32{f[3]}} & a & b & ~c) | ({32{f[2]}} & ~a & b & ~c)
             | ({32{f[1]}} & a & ~b & ~c) | ({32{f[0]}} & ~a & ~b & ~c);
  endfunction : bool_exp

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic send(input logic [63:0] w, input logic m);
    @(posedge core_clk);
    ctl      <= nxt;
    req      <= 1'h1;
    req_word <= w;
    req_misc <= m;
    @(posedge core_clk);
    req <= 1'h0;
  endtask : send

  task automatic finish_op;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (issue && n < 40);
    if (issue) begin
      fail_count++;
      $display("[ERR] issue taken expected 1 seen 0");
      wrap_up();
    end
  endtask : finish_op

  task automatic op(input logic [63:0] w, input logic m);
    send(w, m);
    finish_op();
  endtask : op

  initial begin
    rst_n = 1'h0;
    req = 1'h0;
    req_misc = 1'h0;
    req_word = 64'h0;
    ctl = '0;
    nxt = '0;
    fail_count = 0;
    checked = 0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    #1;
    `CHK("reset outs", 41'h0, {result, mask_flags_register, gie, gloop, stall, result_valid, illegal_op})
    nxt.ops = {VA, VB, VC};
    for (int k = 0; k < 9; k++) begin
      fs = (k == 8) ? 8'hFF : 8'h01 << k;
      op({5'h00, fs, 51'h0}, 1'h0);
      `CHK("bool result", bool_exp(fs, VA, VB, VC), result)
      `CHK("bool valid", 1'h1, result_valid)
    end
    nxt.op_class = 3'h1;
    for (int s = 0; s < 2; s++)
      for (int c = 1; c < 16; c++) begin
        nxt.sign = s[0];
        op(arith_word(c[3:0], 4'h0), 1'h0);
        `CHK("arith", arith_exp(c[3:0], s[0], VA, VB, VC), result)
      end
    nxt.ops = {32'h10203040, 32'h01020304, 32'h01000100};
    nxt.mf_expand = 4'h5;
    nxt.op_class = 3'h0;
    op(arith_word(4'h6, 4'h0), 1'h0);
    `CHK("part addsub", 32'h0F222D44, result)
    nxt.op_class = 3'h5;
    op(arith_word(4'h9, 4'h0), 1'h0);
    `CHK("part subadd", 32'h111E333C, result)
    nxt.ops = {VA, VB, VC};
    nxt.status_carry = 1'h1;
    op(arith_word(4'hA, 4'h1), 1'h0);
    `CHK("carry in", VA + VB + 32'h1, result)
    op(arith_word(4'hA, 4'h4), 1'h0);
    `CHK("a zero", VB, result)
    op(arith_word(4'hA, 4'h5), 1'h0);
    `CHK("a zero cin", VB + 32'h1, result)
    nxt.status_carry = 1'h0;
    op(arith_word(4'hA, 4'h1), 1'h0);
    `CHK("carry clear", VA + VB, result)
    for (int m = 0; m < 2; m++)
      for (int d = 0; d < 4; d++) begin
        nxt.maskgen = m[0];
        md = {1'h0, d[1], 1'h1, d[0]};
        op(arith_word(4'hA, md), 1'h0);
        `CHK("detect en", ~m[0], detect_en)
        `CHK("mod maskgen", m[0], modified_maskgen)
        if (!m[0]) `CHK("detect mode", d[1:0], detect_mode)
      end
    nxt.ops = {32'hFFFF0080, 32'h01000080, VC};
    nxt.mask_status_select = 4'h6;
    op(arith_word(4'hA, 4'h8), 1'h0);
    `CHK("flag carry", 4'h9, mask_flags_register)
    `CHK("sum", 32'h00FF0100, result)
    op(arith_word(4'hA, 4'hE), 1'h0);
    `CHK("flag keep", 4'h9, mask_flags_register)
    op(arith_word(4'hA, 4'hB), 1'h0);
    `CHK("flag rot byte", 4'h6, mask_flags_register)
    op(arith_word(4'hA, 4'h9), 1'h0);
    `CHK("flag status", 4'h6, mask_flags_register)
    op(arith_word(4'hA, 4'hF), 1'h0);
    `CHK("rsv flags", 4'h6, mask_flags_register)
    `CHK("rsv illegal", 1'h1, illegal_op)
    `CHK("rsv no result", 1'h0, result_valid)
    nxt.part_size = 2'h2;
    nxt.mask_status_select = 4'h0;
    foreach (fm[i]) begin
      op(arith_word(4'hA, fm[i]), 1'h0);
      `CHK("flag word", fexp[i], mask_flags_register)
    end
    foreach (mc[i]) begin
      op({20'h0, mc[i], 39'h0}, 1'h1);
      `CHK("gie", mexp[i][1], gie)
      `CHK("gloop", mexp[i][0], gloop)
      `CHK("misc illegal", mexp[i][2], illegal_op)
      `CHK("misc no result", 1'h0, result_valid)
      `CHK("misc keeps result", 32'h00FF0100, result)
      `CHK("misc flags", 4'h0, mask_flags_register)
    end
    nxt.queue_bit = 1'h1;
    op({20'h0, 5'h01, 39'h0}, 1'h1);
    `CHK("stall set", 1'h1, stall)
    send({20'h0, 5'h02, 39'h0}, 1'h1);
    repeat (4) @(posedge core_clk);
    #1;
    `CHK("held stall", 1'h1, stall)
    `CHK("held gie", 1'h0, gie)
    nxt.queue_bit = 1'h0;
    @(posedge core_clk);
    ctl <= nxt;
    finish_op();
    `CHK("released gie", 1'h1, gie)
    `CHK("released stall", 1'h0, stall)
    wrap_up();
  end
endmodule : du_opcode_decode_test
